/* File: ior_pkg.sv */
/*
 * Constants, types and register map for the inertial output register bank.
 * Assumes the serial front end resolves each host read to a byte address.
 */
package ior_pkg;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [6:0]  ADDR_RATE_X_LOW    = 7'h04;
    localparam logic [6:0]  ADDR_RATE_X_HIGH   = 7'h06;
    localparam logic [6:0]  ADDR_RATE_Y_LOW    = 7'h08;
    localparam logic [6:0]  ADDR_RATE_Y_HIGH   = 7'h0a;
    localparam logic [6:0]  ADDR_RATE_Z_LOW    = 7'h0c;
    localparam logic [6:0]  ADDR_RATE_Z_HIGH   = 7'h0e;
    localparam logic [6:0]  ADDR_LINEAR_X_LOW  = 7'h10;
    localparam logic [6:0]  ADDR_LINEAR_X_HIGH = 7'h12;
    localparam logic [5:0]  FIRST_WORD         = 6'h02;
    localparam logic [5:0]  LAST_WORD          = 6'h09;

    // ****************************************************************
    // field layout and reset values
    // ****************************************************************
    localparam int          HIGH_LSB           = 16;
    localparam int          NUM_CHAN           = 4;
    localparam logic [15:0] UNMAPPED_WORD      = 16'h0000;
    localparam logic [31:0] MEAS_RESET         = 32'h0000_0000;

    // ****************************************************************
    // full scale limits of the 32-bit values
    // ****************************************************************
    localparam logic [31:0] RATE_POS_FS        = 32'h4e20_0000;
    localparam logic [31:0] RATE_NEG_FS        = 32'hb1e0_0000;
    localparam logic [31:0] ACCEL_POS_FS       = 32'h7d00_0000;
    localparam logic [31:0] ACCEL_NEG_FS       = 32'h8300_0000;

    // ****************************************************************
    // rate range variants and their scale factors
    // ****************************************************************
    typedef enum logic [2:0] {
        RANGE_125  = 3'h1,
        RANGE_500  = 3'h2,
        RANGE_2000 = 3'h4
    } ior_range_e;

    localparam logic [7:0]  SCALE_125          = 8'ha0;
    localparam logic [7:0]  SCALE_500          = 8'h28;
    localparam logic [7:0]  SCALE_2000         = 8'h0a;

    // one coherent sample from the signal chain
    typedef struct packed {
        logic [31:0] rate_x;
        logic [31:0] rate_y;
        logic [31:0] rate_z;
        logic [31:0] linear_x;
    } ior_sample_s;

    // one host read request
    typedef struct packed {
        logic       en;
        logic [6:0] addr;
    } ior_rd_req_s;

endpackage : ior_pkg

/* File: ior_sat.sv */
/*
 * Saturating limiter for one 32-bit twos-complement measurement.
 * Assumes pos_fs is not below neg_fs as signed values.
 */
`timescale 1ns/1ps

module ior_sat (
    input  wire logic [31:0] raw,
    input  wire logic [31:0] pos_fs,
    input  wire logic [31:0] neg_fs,
    output logic      [31:0] sat
);

    always_comb begin
        if ($signed(raw) > $signed(pos_fs)) begin
            sat = pos_fs;
        end else if ($signed(raw) < $signed(neg_fs)) begin
            sat = neg_fs;
        end else begin
            sat = raw;
        end
    end

endmodule : ior_sat

/* File: ior_regs.sv */
/*
 * Read-only output register bank: three rate axes and x linear acceleration,
 * each a high word and a low resolution word.
 * Assumes a serial front end presents reads as one-cycle requests and that
 * the signal chain presents coherent samples with a one-cycle valid.
 */
`timescale 1ns/1ps

// How it works
// RULE_01: x rate low word sits at 0x04, high word at 0x06.
// RULE_02: y rate low word sits at 0x08, high word at 0x0a.
// RULE_03: z rate low word sits at 0x0c, high word at 0x0e.
// RULE_04: rate high word is twos complement, zero rotation reads 0x0000.
// RULE_05: x acceleration low word sits at 0x10, high word at 0x12.
// RULE_06: acceleration high word is twos complement over plus or minus 40 g.
// RULE_07: high word above low word forms one 32-bit twos-complement value.
// RULE_08: acceleration full scale is 0x7d00 positive and 0x8300 negative.
// RULE_09: rate scale factor is 160, 40 or 10 per range variant.
// RULE_10: both words of a measurement update together from one sample.
module ior_regs #(
    parameter ior_pkg::ior_range_e RANGE = ior_pkg::RANGE_125
) (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 sample_valid,
    input  wire ior_pkg::ior_sample_s sample,
    input  wire ior_pkg::ior_rd_req_s rd_req,
    output logic                      rd_valid,
    output logic               [15:0] rd_data,
    output logic                      rd_unmapped,
    output logic                [7:0] rate_scale
);

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    // returns {hit, channel[1:0], high_half}
    function automatic logic [3:0] word_decode(input logic [6:0] addr);
        logic [5:0] word;
        logic [5:0] idx;
        word = addr[6:1];
        idx  = word - ior_pkg::FIRST_WORD;
        if (word >= ior_pkg::FIRST_WORD && word <= ior_pkg::LAST_WORD) begin
            word_decode = {1'b1, idx[2:0]};
        end else begin
            word_decode = 4'h0;
        end
    endfunction : word_decode

    function automatic logic [7:0] scale_of(input ior_pkg::ior_range_e r);
        case (r)
            ior_pkg::RANGE_125:  scale_of = ior_pkg::SCALE_125;
            ior_pkg::RANGE_500:  scale_of = ior_pkg::SCALE_500;
            ior_pkg::RANGE_2000: scale_of = ior_pkg::SCALE_2000;
            default:             scale_of = ior_pkg::SCALE_125;
        endcase
    endfunction : scale_of

    // ****************************************************************
    // limiting of each channel
    // ****************************************************************
    logic [ior_pkg::NUM_CHAN-1:0][31:0] raw;
    logic [ior_pkg::NUM_CHAN-1:0][31:0] pos_fs;
    logic [ior_pkg::NUM_CHAN-1:0][31:0] neg_fs;
    logic [ior_pkg::NUM_CHAN-1:0][31:0] clamped;

    // channel 0..2 rate x,y,z, channel 3 linear x
    assign raw[0]    = sample.rate_x;
    assign raw[1]    = sample.rate_y;
    assign raw[2]    = sample.rate_z;
    assign raw[3]    = sample.linear_x;
    assign pos_fs[0] = ior_pkg::RATE_POS_FS;
    assign pos_fs[1] = ior_pkg::RATE_POS_FS;
    assign pos_fs[2] = ior_pkg::RATE_POS_FS;
    assign pos_fs[3] = ior_pkg::ACCEL_POS_FS;  // RULE_06 RULE_08
    assign neg_fs[0] = ior_pkg::RATE_NEG_FS;
    assign neg_fs[1] = ior_pkg::RATE_NEG_FS;
    assign neg_fs[2] = ior_pkg::RATE_NEG_FS;
    assign neg_fs[3] = ior_pkg::ACCEL_NEG_FS;  // RULE_08

    genvar c;
    generate
        for (c = 0; c < ior_pkg::NUM_CHAN; c++) begin : g_sat
            ior_sat u_sat (
                .raw    (raw[c]),
                .pos_fs (pos_fs[c]),
                .neg_fs (neg_fs[c]),
                .sat    (clamped[c])
            );
        end
    endgenerate

    // ****************************************************************
    // measurement registers
    // ****************************************************************
    logic [ior_pkg::NUM_CHAN-1:0][31:0] meas;
    logic [ior_pkg::NUM_CHAN-1:0][31:0] next_meas;

    always_comb begin
        next_meas = meas;
        if (sample_valid) begin
            next_meas = clamped;  // RULE_10
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            meas <= {ior_pkg::NUM_CHAN{ior_pkg::MEAS_RESET}};
        end else begin
            meas <= next_meas;
        end
    end

    // ****************************************************************
    // read port
    // ****************************************************************
    logic [3:0]  dec;
    logic [31:0] sel_meas;
    logic        next_rd_valid;
    logic [15:0] next_rd_data;
    logic        next_rd_unmapped;

    always_comb begin
        dec              = word_decode(rd_req.addr);  // RULE_01 RULE_02 RULE_03 RULE_05
        sel_meas         = meas[dec[2:1]];
        next_rd_valid    = rd_req.en;
        next_rd_data     = rd_data;
        next_rd_unmapped = rd_unmapped;
        if (rd_req.en) begin
            next_rd_unmapped = !dec[3];
            if (!dec[3]) begin
                next_rd_data = ior_pkg::UNMAPPED_WORD;
            end else if (dec[0]) begin
                next_rd_data = sel_meas[31:ior_pkg::HIGH_LSB];  // RULE_04 RULE_06 RULE_07
            end else begin
                next_rd_data = sel_meas[ior_pkg::HIGH_LSB-1:0];  // RULE_07
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_valid    <= 1'b0;
            rd_data     <= ior_pkg::UNMAPPED_WORD;
            rd_unmapped <= 1'b0;
            rate_scale  <= scale_of(RANGE);
        end else begin
            rd_valid    <= next_rd_valid;
            rd_data     <= next_rd_data;
            rd_unmapped <= next_rd_unmapped;
            rate_scale  <= scale_of(RANGE);  // RULE_09
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_read(logic [6:0] a);
        rd_req.en && rd_req.addr == a;
    endsequence

    property p_word(logic [6:0] a, logic [15:0] w);
        @(posedge clk) disable iff (!rstn)
        s_read(a) |=> rd_valid && !rd_unmapped && rd_data == $past(w);
    endproperty

    a_rate_x_low:  assert property (p_word(ior_pkg::ADDR_RATE_X_LOW, meas[0][15:0])) // RULE_01
        else $error("rate x low word read wrong");
    a_rate_x_high: assert property (p_word(ior_pkg::ADDR_RATE_X_HIGH, meas[0][31:16])) // RULE_01
        else $error("rate x high word read wrong");
    a_rate_y_high: assert property (p_word(ior_pkg::ADDR_RATE_Y_HIGH, meas[1][31:16])) // RULE_02
        else $error("rate y high word read wrong");
    a_rate_z_low:  assert property (p_word(ior_pkg::ADDR_RATE_Z_LOW, meas[2][15:0])) // RULE_03
        else $error("rate z low word read wrong");
    a_linear_x_high: assert property (p_word(ior_pkg::ADDR_LINEAR_X_HIGH, meas[3][31:16])) // RULE_05
        else $error("linear x high word read wrong");

    a_rate_zero_reads: assert property ( // RULE_04
        @(posedge clk) disable iff (!rstn)
        (sample_valid && sample.rate_z == 32'h0000_0000) ##1 !sample_valid
        ##1 s_read(ior_pkg::ADDR_RATE_Z_HIGH)
        |=> rd_data == 16'h0000)
        else $error("zero rotation did not read as zero");

    a_accel_range: assert property ( // RULE_06
        @(posedge clk) disable iff (!rstn)
        $signed(meas[3]) <= $signed(ior_pkg::ACCEL_POS_FS)
        && $signed(meas[3]) >= $signed(ior_pkg::ACCEL_NEG_FS))
        else $error("acceleration outside full scale");

    a_accel_clip: assert property ( // RULE_08
        @(posedge clk) disable iff (!rstn)
        sample_valid && $signed(sample.linear_x) < $signed(ior_pkg::ACCEL_NEG_FS)
        |=> meas[3][31:16] == 16'h8300 && meas[3][15:0] == 16'h0000)
        else $error("negative acceleration not clipped to full scale");

    a_sample_coherent: assert property ( // RULE_10
        @(posedge clk) disable iff (!rstn)
        sample_valid ##1 !sample_valid
        |-> meas[0] == $past(clamped[0]) && meas[3] == $past(clamped[3]))
        else $error("words of a sample not loaded together");

    a_hold_between: assert property ( // RULE_10
        @(posedge clk) disable iff (!rstn)
        !sample_valid |=> $stable(meas))
        else $error("measurement changed without a sample");

    a_pair_value: assert property ( // RULE_07
        @(posedge clk) disable iff (!rstn)
        s_read(ior_pkg::ADDR_RATE_Y_LOW) ##1 s_read(ior_pkg::ADDR_RATE_Y_HIGH)
        ##0 !$past(sample_valid)
        |=> {rd_data, $past(rd_data)} == $past(meas[1]))
        else $error("high and low words do not form the 32-bit value");

    a_scale_factor: assert property ( // RULE_09
        @(posedge clk) disable iff (!rstn)
        (RANGE == ior_pkg::RANGE_125  && rate_scale == 8'ha0)
        || (RANGE == ior_pkg::RANGE_500  && rate_scale == 8'h28)
        || (RANGE == ior_pkg::RANGE_2000 && rate_scale == 8'h0a))
        else $error("rate scale factor wrong for range");

    a_unmapped_zero: assert property (
        @(posedge clk) disable iff (!rstn)
        rd_req.en && !dec[3]
        |=> rd_valid && rd_unmapped && rd_data == 16'h0000)
        else $error("unmapped read did not return zero");

    a_valid_pulse: assert property (
        @(posedge clk) disable iff (!rstn)
        rd_req.en |=> rd_valid)
        else $error("read not answered in the next cycle");

    a_valid_quiet: assert property (
        @(posedge clk) disable iff (!rstn)
        !rd_req.en |=> !rd_valid)
        else $error("answer without a read");

    a_data_holds: assert property (
        @(posedge clk) disable iff (!rstn)
        !rd_req.en |=> $stable(rd_data) && $stable(rd_unmapped))
        else $error("read data changed without a read");

endmodule : ior_regs

/* File: ior_host_model.sv */
/*
 * Host side model for the inertial output register bank read port.
 * Assumes the bank answers each one-cycle read with rd_valid one cycle later.
 */
`timescale 1ns/1ps

module ior_host_model (
    input  wire logic            clk,
    input  wire logic            rd_valid,
    input  wire logic     [15:0] rd_data,
    input  wire logic            rd_unmapped,
    output ior_pkg::ior_rd_req_s rd_req
);
    // ****************************************************************
    // answers collected in order, {unmapped, data}
    // ****************************************************************
    logic [16:0] got[$];

    initial rd_req = '0;

    always @(negedge clk) begin
        if (rd_valid === 1'b1) begin
            got.push_back({rd_unmapped, rd_data});
        end
    end

    // one read per call, back to back when called in a row
    task automatic req(input logic [6:0] a);
        @(negedge clk);
        rd_req <= {1'b1, a};
    endtask : req

    // released address shows the inverse of the last one
    task automatic idle();
        @(negedge clk);
        rd_req <= {1'b0, ~rd_req.addr};
    endtask : idle

    task automatic pop(output logic [16:0] v);
        #1;
        v = (got.size() > 0) ? got.pop_front() : 17'h1ffff;
    endtask : pop
endmodule : ior_host_model

/* File: tb_top.sv */
/*
 * Self-checking bench for the inertial output register bank.
 * Assumes ior_pkg, ior_sat, ior_regs and ior_host_model are compiled first.
 */
`timescale 1ns/1ps

module tb_top;
    typedef struct packed {
        logic        ph;
        logic [6:0]  a;
        logic [16:0] e;
    } ior_row_s;

    logic                 clk;
    logic                 rstn;
    logic                 sample_valid;
    ior_pkg::ior_sample_s sample;
    ior_pkg::ior_rd_req_s rd_req;
    logic                 rd_valid;
    logic          [15:0] rd_data;
    logic                 rd_unmapped;
    logic           [7:0] rate_scale;
    logic           [7:0] scale_500;
    logic           [7:0] scale_2000;
    logic          [16:0] v;
    int                   n_mismatch;
    int                   tests_run;
    ior_pkg::ior_sample_s smp [2];
    ior_row_s             rows [19];

    initial clk = 1'b0;
    always #25 clk = ~clk;

    ior_regs dut (.clk(clk), .rstn(rstn), .sample_valid(sample_valid), .sample(sample),
        .rd_req(rd_req), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_unmapped(rd_unmapped), .rate_scale(rate_scale));
    ior_regs #(.RANGE(ior_pkg::RANGE_500)) dut_500 (.clk(clk), .rstn(rstn),
        .sample_valid(sample_valid), .sample(sample), .rd_req(rd_req), .rd_valid(),
        .rd_data(), .rd_unmapped(), .rate_scale(scale_500));
    ior_regs #(.RANGE(ior_pkg::RANGE_2000)) dut_2000 (.clk(clk), .rstn(rstn),
        .sample_valid(sample_valid), .sample(sample), .rd_req(rd_req), .rd_valid(),
        .rd_data(), .rd_unmapped(), .rate_scale(scale_2000));
    ior_host_model host (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_unmapped(rd_unmapped), .rd_req(rd_req));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic load(input ior_pkg::ior_sample_s s);
        @(negedge clk);
        sample       <= s;
        sample_valid <= 1'b1;
        @(negedge clk);
        sample_valid <= 1'b0;
        sample       <= ~s;
    endtask : load

    task automatic read_one(input logic [6:0] a, input logic [16:0] e);
        host.req(a);
        host.idle();
        host.pop(v);
        check(v, e);
    endtask : read_one

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #(2000 * 50);
        n_mismatch++;
        end_of_test();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        rstn = 1'b0; sample_valid = 1'b0; sample = '0; n_mismatch = 0; tests_run = 0;
        smp[0] = {32'h1234_5678, 32'hfffe_8001, 32'hb1e0_0001, 32'h7d00_0000};
        smp[1] = {32'h7fff_ffff, 32'h8000_0000, 32'h0000_0000, 32'h8000_0001};
        rows = '{'{0, 7'h04, 17'h05678}, '{0, 7'h05, 17'h05678}, '{0, 7'h06, 17'h01234},
            '{0, 7'h08, 17'h08001}, '{0, 7'h0a, 17'h0fffe}, '{0, 7'h0c, 17'h00001},
            '{0, 7'h0e, 17'h0b1e0}, '{0, 7'h11, 17'h00000}, '{0, 7'h12, 17'h07d00},
            '{0, 7'h02, 17'h10000}, '{0, 7'h03, 17'h10000}, '{0, 7'h14, 17'h10000},
            '{0, 7'h7f, 17'h10000}, '{1, 7'h0e, 17'h00000}, '{1, 7'h06, 17'h04e20},
            '{1, 7'h0a, 17'h0b1e0}, '{1, 7'h04, 17'h00000}, '{1, 7'h10, 17'h00000},
            '{1, 7'h13, 17'h08300}};
        repeat (6) @(negedge clk);
        rstn <= 1'b1;
        check(17'(rate_scale), 17'h000a0);
        check(17'(scale_500), 17'h00028);
        check(17'(scale_2000), 17'h0000a);
        read_one(7'h06, 17'h00000);
        for (int p = 0; p < 2; p++) begin
            load(smp[p]);
            foreach (rows[i]) if (rows[i].ph == p[0]) host.req(rows[i].a);
            host.idle();
            foreach (rows[i]) begin
                if (rows[i].ph == p[0]) begin
                    host.pop(v);
                    check(v, rows[i].e);
                end
            end
        end
        // read taken on the loading edge still sees the old sample
        host.req(7'h06);
        sample       <= smp[0];
        sample_valid <= 1'b1;
        host.req(7'h04);
        sample_valid <= 1'b0;
        host.req(7'h06);
        host.idle();
        host.pop(v);
        check(v, 17'h04e20);
        host.pop(v);
        check(v, 17'h05678);
        host.pop(v);
        check(v, 17'h01234);
        // second reset in mid-run clears the measurements
        @(negedge clk);
        rstn <= 1'b0;
        repeat (2) @(negedge clk);
        rstn <= 1'b1;
        check({rd_unmapped, rd_data}, 17'h00000);
        read_one(7'h12, 17'h00000);
        check(17'(host.got.size()), 17'h00000);
        end_of_test();
    end
endmodule : tb_top
